// *** core/vih_arbiter.sv ***
// vih_arbiter.sv: two-level fixed order arbiter of enabled pending sources
// assumes pending, enable and priority vectors are on the core clock
`timescale 1ns/10ps
module vih_arbiter
	import vih_pkg::*;
#(
	parameter int NUM_SRC = `VIH_NUM_SRC
)(
	input  wire logic [NUM_SRC-1:0] req_i,
	input  wire logic [NUM_SRC-1:0] prio_i,
	output vih_req_t                win_o
);
	// =========================================
	// lowest order wins inside each level
	logic [NUM_SRC-1:0] hi_req;
	logic [NUM_SRC-1:0] lo_req;
	logic [4:0]         hi_idx;
	logic [4:0]         lo_idx;
	logic [4:0]         sel_idx;

	assign hi_req = req_i & prio_i;
	assign lo_req = req_i & ~prio_i;

	always_comb
	begin
		hi_idx = 5'h00;
		lo_idx = 5'h00;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (hi_req[i])
				hi_idx = 5'(i);
			if (lo_req[i])
				lo_idx = 5'(i);
		end
	end

	assign sel_idx     = (|hi_req) ? hi_idx : lo_idx;
	assign win_o.valid = |req_i;
	assign win_o.high  = |hi_req;
	assign win_o.index = sel_idx;
	assign win_o.addr  = `VIH_VEC_BASE + {8'h00, sel_idx, 3'h0};
endmodule : vih_arbiter

// *** core/vih_handler.sv ***
// vih_handler.sv: vectored interrupt handler, 22 sources, two levels
// assumes the cpu reports instruction boundaries and return completion on the core clock
`timescale 1ns/10ps
module vih_handler
	import vih_pkg::*;
#(
	parameter int NUM_SRC = `VIH_NUM_SRC
)(
	input  wire logic               core_clk_i,
	input  wire logic               rst_n_i,
	// register port
	input  wire logic [7:0]         reg_addr_i,
	input  wire logic [7:0]         reg_wdata_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	output logic [7:0]              reg_rdata_o,
	// peripheral events, one-cycle pulses on the core clock
	input  wire logic [NUM_SRC-1:0] periph_event_i,
	// peripheral flag clears from software paths outside this block
	input  wire logic [NUM_SRC-1:0] periph_clear_i,
	// external pins
	input  wire logic               ext0_request_pin_n_i,
	input  wire logic               ext1_request_pin_n_i,
	input  wire logic               ext6_pin_i,
	input  wire logic               ext7_pin_i,
	// cpu side
	input  wire logic               instr_done_i,
	input  wire logic               return_from_int_instr_done_i,
	output logic                    call_req_o,
	output logic [15:0]             call_addr_o,
	output logic [4:0]              call_src_o,
	output logic                    call_busy_o,
	output logic [1:0]              active_level_o
);
	// =========================================
	// parameter check
	initial
	begin
		if (NUM_SRC != `VIH_NUM_SRC)
			$error("vih_handler: source count must be 22");
	end

	// =========================================
	// pin synchronisers
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic [3:0] pin_prev;

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_meta <= 4'hF;
			pin_sync <= 4'hF;
			pin_prev <= 4'hF;
		end
		else
		begin
			pin_meta <= {ext7_pin_i, ext6_pin_i, ext1_request_pin_n_i, ext0_request_pin_n_i};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// =========================================
	// control registers
	logic [7:0] int_enable_reg;
	logic [7:0] ext_int_enable_reg1;
	logic [7:0] ext_int_enable_reg2;
	logic [7:0] int_priority_reg;
	logic [7:0] ext_int_priority_reg1;
	logic [7:0] ext_int_priority_reg2;
	logic       ext0_trigger_type;
	logic       ext1_trigger_type;
	logic       ext6_polarity;
	logic       ext7_polarity;

	wire wr_ie   = reg_wr_i && (reg_addr_i == `VIH_A_IE);
	wire wr_eie1 = reg_wr_i && (reg_addr_i == `VIH_A_EIE1);
	wire wr_ext_int_enable_reg2 = reg_wr_i && (reg_addr_i == `VIH_A_EXT_INT_ENABLE_REG2);
	wire wr_ip   = reg_wr_i && (reg_addr_i == `VIH_A_IP);
	wire wr_eip1 = reg_wr_i && (reg_addr_i == `VIH_A_EIP1);
	wire wr_ext_int_priority_reg2 = reg_wr_i && (reg_addr_i == `VIH_A_EXT_INT_PRIORITY_REG2);
	wire wr_timer_control_reg = reg_wr_i && (reg_addr_i == `VIH_A_TIMER_CONTROL_REG);
	wire wr_port3_int_flag_reg = reg_wr_i && (reg_addr_i == `VIH_A_PORT3_INT_FLAG_REG);
	wire wr_pnd0 = reg_wr_i && (reg_addr_i == `VIH_A_PEND0);
	wire wr_pnd1 = reg_wr_i && (reg_addr_i == `VIH_A_PEND1);
	wire wr_pnd2 = reg_wr_i && (reg_addr_i == `VIH_A_PEND2);

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			int_enable_reg        <= `VIH_RST_BYTE;
			ext_int_enable_reg1   <= `VIH_RST_BYTE;
			ext_int_enable_reg2   <= `VIH_RST_BYTE;
			int_priority_reg      <= `VIH_RST_BYTE;
			ext_int_priority_reg1 <= `VIH_RST_BYTE;
			ext_int_priority_reg2 <= `VIH_RST_BYTE;
			ext0_trigger_type     <= 1'b0;
			ext1_trigger_type     <= 1'b0;
			ext6_polarity         <= 1'b0;
			ext7_polarity         <= 1'b0;
		end
		else
		begin
			if (wr_ie)
				int_enable_reg <= reg_wdata_i;
			if (wr_eie1)
				ext_int_enable_reg1 <= reg_wdata_i;
			if (wr_ext_int_enable_reg2)
				ext_int_enable_reg2 <= reg_wdata_i;
			if (wr_ip)
				int_priority_reg <= reg_wdata_i;
			if (wr_eip1)
				ext_int_priority_reg1 <= reg_wdata_i;
			if (wr_ext_int_priority_reg2)
				ext_int_priority_reg2 <= reg_wdata_i;
			if (wr_timer_control_reg)
			begin
				ext0_trigger_type <= reg_wdata_i[`VIH_IT0_BIT];
				ext1_trigger_type <= reg_wdata_i[`VIH_IT1_BIT];
			end
			if (wr_port3_int_flag_reg)
			begin
				ext6_polarity <= reg_wdata_i[`VIH_P3_POL6_BIT];
				ext7_polarity <= reg_wdata_i[`VIH_P3_POL7_BIT];
			end
		end
	end

	// =========================================
	// enable and priority vectors
	logic [NUM_SRC-1:0] src_enable;
	logic [NUM_SRC-1:0] src_prio;
	logic               global_int_enable;

	assign global_int_enable = int_enable_reg[`VIH_GIE_BIT];
	assign src_enable = {ext_int_enable_reg2, ext_int_enable_reg1, int_enable_reg[5:0]};
	assign src_prio   = {ext_int_priority_reg2, ext_int_priority_reg1, int_priority_reg[5:0]};

	// =========================================
	// pending flags
	logic [NUM_SRC-1:0] pend;
	logic [NUM_SRC-1:0] next_pend;
	logic [NUM_SRC-1:0] hw_set;
	logic [NUM_SRC-1:0] sw_wr_sel;
	logic [NUM_SRC-1:0] sw_wr_val;
	logic [NUM_SRC-1:0] auto_clr;
	logic [NUM_SRC-1:0] level_mode;
	logic [NUM_SRC-1:0] level_val;
	logic               fall0;
	logic               fall1;
	logic               edge6;
	logic               edge7;
	logic               call_take;
	vih_req_t           win;
	vih_req_t           held;

	assign fall0 = pin_prev[0] & ~pin_sync[0];
	assign fall1 = pin_prev[1] & ~pin_sync[1];
	assign edge6 = ext6_polarity ? (~pin_prev[2] & pin_sync[2]) : (pin_prev[2] & ~pin_sync[2]);
	assign edge7 = ext7_polarity ? (~pin_prev[3] & pin_sync[3]) : (pin_prev[3] & ~pin_sync[3]);

	always_comb
	begin
		hw_set     = periph_event_i;
		level_mode = '0;
		level_val  = '0;
		hw_set[`VIH_SRC_EXT0] = ext0_trigger_type & fall0;
		hw_set[`VIH_SRC_EXT1] = ext1_trigger_type & fall1;
		hw_set[`VIH_SRC_EXT6] = edge6;
		hw_set[`VIH_SRC_EXT7] = edge7;
		level_mode[`VIH_SRC_EXT0] = ~ext0_trigger_type;
		level_mode[`VIH_SRC_EXT1] = ~ext1_trigger_type;
		level_val[`VIH_SRC_EXT0]  = ~pin_sync[0];
		level_val[`VIH_SRC_EXT1]  = ~pin_sync[1];
	end

	always_comb
	begin
		sw_wr_sel = '0;
		sw_wr_val = '0;
		sw_wr_sel[`VIH_SRC_EXT0] = wr_timer_control_reg;
		sw_wr_sel[`VIH_SRC_EXT1] = wr_timer_control_reg;
		sw_wr_val[`VIH_SRC_EXT0] = reg_wdata_i[`VIH_IE0_BIT];
		sw_wr_val[`VIH_SRC_EXT1] = reg_wdata_i[`VIH_IE1_BIT];
		sw_wr_sel[`VIH_SRC_EXT6] = wr_port3_int_flag_reg;
		sw_wr_sel[`VIH_SRC_EXT7] = wr_port3_int_flag_reg;
		sw_wr_val[`VIH_SRC_EXT6] = reg_wdata_i[`VIH_P3_IE6_BIT];
		sw_wr_val[`VIH_SRC_EXT7] = reg_wdata_i[`VIH_P3_IE7_BIT];
		sw_wr_sel[7:0]   = sw_wr_sel[7:0] | {8{wr_pnd0}};
		sw_wr_val[7:0]   = wr_pnd0 ? reg_wdata_i : sw_wr_val[7:0];
		sw_wr_sel[15:8]  = {8{wr_pnd1}};
		sw_wr_val[15:8]  = reg_wdata_i;
		sw_wr_sel[17:16] = {2{wr_pnd2}};
		sw_wr_val[17:16] = reg_wdata_i[1:0];
		sw_wr_sel[21:20] = {2{wr_pnd2}};
		sw_wr_val[21:20] = reg_wdata_i[5:4];
	end

	// edge-mode ext 0/1 and timers 0/1 clear themselves on the call
	always_comb
	begin
		auto_clr = '0;
		if (call_take)
		begin
			if ((held.index == 5'(`VIH_SRC_EXT0) && ext0_trigger_type) ||
			    (held.index == 5'(`VIH_SRC_EXT1) && ext1_trigger_type) ||
			    held.index == 5'h01 || held.index == 5'h03)
				auto_clr[held.index] = 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : g_pend
			always_comb
			begin
				if (level_mode[g])
					next_pend[g] = level_val[g];
				else if (hw_set[g])
					next_pend[g] = 1'b1;
				else if (sw_wr_sel[g])
					next_pend[g] = sw_wr_val[g];
				else if (auto_clr[g] || periph_clear_i[g])
					next_pend[g] = 1'b0;
				else
					next_pend[g] = pend[g];
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pend <= '0;
		else
			pend <= next_pend;
	end

	// =========================================
	// arbitration and blocking
	logic [NUM_SRC-1:0] eligible;
	logic [1:0]         act;
	logic               hold_one;
	logic               blocked;

	assign eligible = pend & src_enable & {NUM_SRC{global_int_enable}};

	vih_arbiter #(
		.NUM_SRC (NUM_SRC)
	) u_arb (
		.req_i  (eligible),
		.prio_i (src_prio),
		.win_o  (win)
	);

	// act[1] high level active, act[0] low level active
	assign blocked = act[1] || (act[0] && !win.high) || hold_one;

	// =========================================
	// call sequencer
	vih_state_t state;
	vih_state_t next_state;
	logic [2:0] call_cnt;

	always_comb
	begin
		next_state = state;
		call_take  = 1'b0;
		case (state)
			VIH_RUN:
				if (win.valid && !blocked && instr_done_i)
					next_state = VIH_CALL;
			VIH_CALL:
				if (call_cnt == 3'(`VIH_CALL_CYC - 1))
				begin
					next_state = VIH_RUN;
					call_take  = 1'b1;
				end
			VIH_HOLD:
				next_state = VIH_RUN;
			default:
				next_state = VIH_RUN;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state    <= VIH_RUN;
			call_cnt <= 3'h0;
			held     <= '0;
		end
		else
		begin
			state <= next_state;
			if (state == VIH_RUN && next_state == VIH_CALL)
			begin
				held     <= win;
				call_cnt <= 3'h0;
			end
			else if (state == VIH_CALL)
				call_cnt <= call_cnt + 3'h1;
		end
	end

	// active level record and post-return hold
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			act      <= 2'b00;
			hold_one <= 1'b0;
		end
		else
		begin
			if (call_take)
				act[held.high ? 1 : 0] <= 1'b1;
			else if (return_from_int_instr_done_i)
			begin
				if (act[1])
					act[1] <= 1'b0;
				else
					act[0] <= 1'b0;
			end
			if (return_from_int_instr_done_i)
				hold_one <= 1'b1;
			else if (instr_done_i)
				hold_one <= 1'b0;
		end
	end

	// =========================================
	// cpu outputs
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			call_req_o  <= 1'b0;
			call_addr_o <= `VIH_VEC_RESET;
			call_src_o  <= 5'h00;
		end
		else
		begin
			call_req_o <= call_take;
			if (call_take)
			begin
				call_addr_o <= held.addr;
				call_src_o  <= held.index;
			end
		end
	end

	assign call_busy_o    = (state != VIH_RUN);
	assign active_level_o = act;

	// =========================================
	// register read, data one cycle after the strobe
	logic [7:0] rd_mux;

	always_comb
	begin
		case (reg_addr_i)
			`VIH_A_IE:    rd_mux = int_enable_reg;
			`VIH_A_EIE1:  rd_mux = ext_int_enable_reg1;
			`VIH_A_EXT_INT_ENABLE_REG2:  rd_mux = ext_int_enable_reg2;
			`VIH_A_IP:    rd_mux = int_priority_reg | `VIH_IP_RD_ONES;
			`VIH_A_EIP1:  rd_mux = ext_int_priority_reg1;
			`VIH_A_EXT_INT_PRIORITY_REG2:  rd_mux = ext_int_priority_reg2;
			`VIH_A_TIMER_CONTROL_REG:  rd_mux = {4'h0, pend[`VIH_SRC_EXT1], ext1_trigger_type,
			                        pend[`VIH_SRC_EXT0], ext0_trigger_type};
			`VIH_A_PORT3_INT_FLAG_REG:  rd_mux = {1'b0, pend[`VIH_SRC_EXT7], pend[`VIH_SRC_EXT6], 2'b00,
			                        ext7_polarity, ext6_polarity, 1'b0};
			`VIH_A_PEND0: rd_mux = pend[7:0];
			`VIH_A_PEND1: rd_mux = pend[15:8];
			`VIH_A_PEND2: rd_mux = {2'b00, pend[21:16]};
			`VIH_A_STAT:  rd_mux = {3'h0, held.index[4:0]} ^ {act, 6'h00};
			default:      rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			reg_rdata_o <= rd_mux;
		else
			reg_rdata_o <= 8'h00;
	end
endmodule : vih_handler

// *** include/vih_consts.svh ***
// vih_consts.svh: offsets, field positions, reset values and timing counts of the interrupt handler
// assumes a single 50 MHz core clock and an sfr-style plain register port
//
// What this block does
// - 22 sources, two priority levels, pending flags
// - flags set on event regardless of enable
// - after instruction ends, long call to vector
// - return resumes the interrupted instruction stream
// - disabled source pending flag is ignored
// - global enable gates all per-source enables
// - only some flags auto-clear on vectoring
// - flag still set after return re-requests
// - software write of one acts as event
// - ext 0/1 active low, level or edge
// - ext 0/1 flags at control bits 1, 3
// - edge mode ext flag clears on vectoring
// - level mode ext flag follows the pin
// - ext 6/7 edge only, selectable polarity
// - fixed vectors 0x0003 to 0x00AB, 8-byte steps
// - high preempts low, high never preempted
// - per-source priority bit, low after reset
// - higher level first, then lower order
// - sample every clock, 1+4 clock response
// - one instruction after return before next call
// - worst case 18 clocks response
// - equal or higher service blocks new request
`ifndef VIH_CONSTS_SVH
`define VIH_CONSTS_SVH

`define VIH_NUM_SRC        22
`define VIH_VEC_BASE       16'h0003
`define VIH_VEC_STEP       16'h0008
`define VIH_VEC_RESET      16'h0000
`define VIH_DETECT_CYC     1
`define VIH_CALL_CYC       4
`define VIH_MIN_RESP_CYC   5
`define VIH_MAX_RESP_CYC   18

// register addresses on the plain port
`define VIH_A_TIMER_CONTROL_REG         8'h88
`define VIH_A_IE           8'hA8
`define VIH_A_IP           8'hB8
`define VIH_A_EIE1         8'hE6
`define VIH_A_EXT_INT_ENABLE_REG2         8'hE7
`define VIH_A_EIP1         8'hF6
`define VIH_A_EXT_INT_PRIORITY_REG2         8'hF7
`define VIH_A_PORT3_INT_FLAG_REG         8'hAD
`define VIH_A_PEND0        8'hC0
`define VIH_A_PEND1        8'hC1
`define VIH_A_PEND2        8'hC2
`define VIH_A_STAT         8'hC3

// field positions
`define VIH_GIE_BIT        7
`define VIH_IT0_BIT        0
`define VIH_IE0_BIT        1
`define VIH_IT1_BIT        2
`define VIH_IE1_BIT        3
`define VIH_P3_IE6_BIT     5
`define VIH_P3_IE7_BIT     6
`define VIH_P3_POL6_BIT    1
`define VIH_P3_POL7_BIT    2
`define VIH_SRC_EXT0       0
`define VIH_SRC_EXT1       2
`define VIH_SRC_EXT6       18
`define VIH_SRC_EXT7       19
`define VIH_IP_RD_ONES     8'hC0
`define VIH_RST_BYTE       8'h00

`endif

// *** include/vih_pkg.sv ***
// vih_pkg.sv: types shared by the interrupt handler
// assumes vih_consts.svh is on the include path
`include "vih_consts.svh"
package vih_pkg;
	typedef logic [`VIH_NUM_SRC-1:0] vih_vec_t;

	typedef struct packed {
		logic        valid;
		logic        high;
		logic [4:0]  index;
		logic [15:0] addr;
	} vih_req_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} vih_bus_t;

	typedef enum logic [1:0] {
		VIH_RUN    = 2'b00,
		VIH_CALL   = 2'b01,
		VIH_HOLD   = 2'b11
	} vih_state_t;
endpackage : vih_pkg

// *** tb/vih_cpu_model.sv ***
// vih_cpu_model.sv: behavioural cpu giving instruction boundaries and returns
// assumes call_req_i is a one-cycle pulse per vector call
`timescale 1ns/10ps
module vih_cpu_model
	import vih_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic call_req_i,
	input  wire logic slow_i,
	input  wire logic return_from_int_instr_cmd_i,
	output logic      instr_done_o,
	output logic      return_from_int_instr_done_o
);
	logic [1:0] gap;
	logic [1:0] depth;
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			gap          <= 2'h0;
			depth        <= 2'h0;
			instr_done_o <= 1'b0;
			return_from_int_instr_done_o  <= 1'b0;
		end
		else
		begin
			gap          <= (slow_i && gap != 2'h2) ? gap + 2'h1 : 2'h0;
			instr_done_o <= (gap == 2'h0) && !return_from_int_instr_cmd_i;
			return_from_int_instr_done_o  <= return_from_int_instr_cmd_i && depth != 2'h0;
			depth        <= depth + {1'b0, call_req_i} - {1'b0, return_from_int_instr_cmd_i && depth != 2'h0};
		end
endmodule : vih_cpu_model

// *** tb/vih_handler_bench.sv ***
// vih_handler_bench.sv: self-checking bench of the vectored interrupt handler
// assumes the cpu model and the bound checker
`timescale 1ns/10ps
module vih_handler_bench;
	logic        core_clk_i;
	logic        rst_n_i = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [21:0] ev = 22'h0;
	logic [21:0] clr = 22'h0;
	logic        p0 = 1'b1;
	logic        p1 = 1'b1;
	logic        p6 = 1'b1;
	logic        p7 = 1'b1;
	logic        slow = 1'b0;
	logic        return_from_int_instr_cmd = 1'b0;
	logic        instr_done, return_from_int_instr_done, call_req_o, call_busy_o;
	logic [7:0]  reg_rdata_o;
	logic [15:0] call_addr_o, laddr;
	logic [4:0]  call_src_o, lsrc;
	logic [1:0]  active_level_o;
	logic [21:0] pd, en, pr;
	logic [7:0]  ra [7] = '{8'hA8, 8'hB8, 8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'h55};
	logic [7:0]  rv [7] = '{8'h00, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          ncall = 0;
	int          seen = 0;
	int          w;

	vih_handler vih_handler_i (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .periph_event_i(ev), .periph_clear_i(clr), .ext0_request_pin_n_i(p0),
		.ext1_request_pin_n_i(p1), .ext6_pin_i(p6), .ext7_pin_i(p7), .instr_done_i(instr_done),
		.return_from_int_instr_done_i(return_from_int_instr_done), .call_req_o, .call_addr_o, .call_src_o, .call_busy_o, .active_level_o);
	vih_cpu_model vih_cpu_model_i (.clk_i(core_clk_i), .rst_n_i, .call_req_i(call_req_o), .slow_i(slow),
		.return_from_int_instr_cmd_i(return_from_int_instr_cmd), .instr_done_o(instr_done), .return_from_int_instr_done_o(return_from_int_instr_done));

	initial
	begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end

	// calls seen on the cpu side
	always @(posedge core_clk_i)
		if (call_req_o === 1'b1)
		begin
			ncall <= ncall + 1;
			lsrc  <= call_src_o;
			laddr <= call_addr_o;
		end

	// ====
	// tasks
	task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		@(posedge core_clk_i);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e, string nm);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(nm, 16'(reg_rdata_o & m), 16'(e));
		@(posedge core_clk_i);
	endtask : rd
	task automatic pulse(logic [21:0] e, logic [21:0] c);
		ev  <= e;
		clr <= c;
		@(posedge core_clk_i);
		ev  <= 22'h0;
		clr <= 22'h0;
		@(posedge core_clk_i);
	endtask : pulse
	task automatic return_from_int_instr();
		return_from_int_instr_cmd <= 1'b1;
		@(posedge core_clk_i);
		return_from_int_instr_cmd <= 1'b0;
		@(posedge core_clk_i);
	endtask : return_from_int_instr
	task automatic expect_call(int s, logic [1:0] l, string nm);
		int k;
		k = 0;
		while (ncall == seen && k < 80)
		begin
			@(posedge core_clk_i);
			#1 k++;
		end
		chk(nm, 16'(ncall - seen), 16'h0001);
		seen = ncall;
		chk(nm, 16'(lsrc), 16'(s));
		chk(nm, laddr, 16'h0003 + 16'(s) * 16'h0008);
		chk(nm, 16'(active_level_o), 16'(l));
	endtask : expect_call
	task automatic quiet(string nm);
		repeat (30) @(posedge core_clk_i);
		#1 chk(nm, 16'(ncall), 16'(seen));
	endtask : quiet
	task automatic fin(string nm);
		$display("test %s done", nm);
	endtask : fin
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	function automatic int win(logic [21:0] p, logic [21:0] h);
		for (int i = 0; i < 22; i++)
			if (p[i] && h[i])
				return i;
		for (int i = 0; i < 22; i++)
			if (p[i])
				return i;
		return -1;
	endfunction : win

	// ====
	// main sequence
	initial
	begin
		void'($urandom(73521));
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		foreach (ra[i]) rd(ra[i], 8'hFF, rv[i], "reset value");
		fin("reset");
		wr(8'hA8, 8'h20);
		pulse(22'h20, 22'h0);
		quiet("global off");
		rd(8'hC0, 8'h20, 8'h20, "flag while off");
		wr(8'hA8, 8'hA0);
		expect_call(5, 2'b01, "global on");
		rd(8'hC0, 8'h20, 8'h20, "flag kept");
		return_from_int_instr();
		expect_call(5, 2'b01, "reentry");
		pulse(22'h0, 22'h20);
		return_from_int_instr();
		quiet("cleared");
		fin("gating");
		wr(8'hE6, 8'h08);
		wr(8'hA8, 8'h82);
		wr(8'hC1, 8'h02);
		expect_call(9, 2'b01, "soft set");
		pulse(22'h0, 22'h200);
		return_from_int_instr();
		pulse(22'h2, 22'h0);
		expect_call(1, 2'b01, "timer");
		rd(8'hC0, 8'h02, 8'h00, "auto clear");
		return_from_int_instr();
		fin("soft");
		wr(8'hE6, 8'h03);
		wr(8'hF6, 8'h01);
		wr(8'hA8, 8'h90);
		pulse(22'h10, 22'h0);
		expect_call(4, 2'b01, "low");
		pulse(22'h80, 22'h10);
		quiet("equal blocked");
		pulse(22'h40, 22'h0);
		expect_call(6, 2'b11, "preempt");
		pulse(22'h0, 22'h40);
		return_from_int_instr();
		quiet("low still active");
		chk("level", 16'(active_level_o), 16'h0001);
		return_from_int_instr();
		expect_call(7, 2'b01, "after return");
		pulse(22'h0, 22'h80);
		return_from_int_instr();
		fin("priority");
		slow <= 1'b1;
		for (int t = 0; t < 16; t++)
		begin
			pd = 22'($urandom) & 22'h33FFFA | 22'h200000;
			en = 22'($urandom) | 22'h200000;
			pr = 22'($urandom);
			wr(8'hA8, {2'b00, en[5:0]});
			wr(8'hE6, en[13:6]);
			wr(8'hE7, en[21:14]);
			wr(8'hB8, {2'b00, pr[5:0]});
			wr(8'hF6, pr[13:6]);
			wr(8'hF7, pr[21:14]);
			pulse(pd, 22'h0);
			wr(8'hA8, {2'b10, en[5:0]});
			w = win(pd & en, pr);
			expect_call(w, pr[w] ? 2'b10 : 2'b01, "arbitration");
			pulse(22'h0, pd);
			return_from_int_instr();
		end
		slow <= 1'b0;
		fin("random");
		wr(8'hB8, 8'h00);
		wr(8'hE6, 8'h00);
		wr(8'hE7, 8'h00);
		wr(8'h88, 8'h00);
		wr(8'hA8, 8'h00);
		p0 <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		rd(8'h88, 8'h02, 8'h02, "level low");
		p0 <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		rd(8'h88, 8'h02, 8'h00, "level high");
		wr(8'hA8, 8'h81);
		p0 <= 1'b0;
		expect_call(0, 2'b01, "level call");
		p0 <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		return_from_int_instr();
		quiet("released");
		wr(8'h88, 8'h01);
		p0 <= 1'b0;
		expect_call(0, 2'b01, "edge call");
		rd(8'h88, 8'h02, 8'h00, "edge auto clear");
		return_from_int_instr();
		quiet("edge once");
		p0 <= 1'b1;
		wr(8'hAD, 8'h02);
		wr(8'hE7, 8'h10);
		p6 <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		p6 <= 1'b1;
		expect_call(18, 2'b01, "ext6 rise");
		rd(8'hAD, 8'h20, 8'h20, "ext6 flag");
		wr(8'hE7, 8'h00);
		return_from_int_instr();
		fin("external");
		print_verdict();
	end

	// the sequence needs some 1000 cycles; allow far more
	initial
	begin
		#400000;
		n_mismatch++;
		print_verdict();
	end
endmodule : vih_handler_bench

// *** tb/vih_handler_chk.sv ***
// vih_handler_chk.sv: port-level checks of the interrupt handler
// assumes one core clock and an active low asynchronous reset
`timescale 1ns/10ps
`include "vih_consts.svh"
module vih_handler_chk
	import vih_pkg::*;
#(
	parameter int NUM_SRC = 22
)(
	input wire logic        core_clk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        return_from_int_instr_done_i,
	input wire logic        call_req_o,
	input wire logic [15:0] call_addr_o,
	input wire logic [4:0]  call_src_o,
	input wire logic        call_busy_o,
	input wire logic [1:0]  active_level_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ====
	// global enable shadow
	logic gie;
	always_ff @(posedge core_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			gie <= 1'b0;
		else if (reg_wr_i && reg_addr_i == `VIH_A_IE)
			gie <= reg_wdata_i[`VIH_GIE_BIT];
	// ====
	// properties
	AST_VEC_ADDR: assert property (call_req_o |-> call_addr_o == 16'h0003 + {8'h00, call_src_o, 3'h0})
		else $error("vector address off");
	AST_SRC_RANGE: assert property (call_req_o |-> call_src_o < NUM_SRC)
		else $error("source index out of range");
	AST_REQ_PULSE: assert property (call_req_o |=> !call_req_o)
		else $error("call request longer than one cycle");
	AST_CALL_SEQ: assert property ($rose(call_busy_o) |-> !call_req_o [*3] ##[1:3] call_req_o)
		else $error("call sequence length off");
	AST_NO_PREEMPT: assert property ($rose(call_busy_o) |-> !active_level_o[1])
		else $error("high level routine preempted");
	AST_LEVEL_SET: assert property (call_req_o |=> active_level_o != 2'b00)
		else $error("active level not recorded");
	AST_HIGH_FREE: assert property ($fell(active_level_o[1]) |-> $past(return_from_int_instr_done_i))
		else $error("high level freed without return");
	AST_LOW_FREE: assert property ($fell(active_level_o[0]) |-> $past(return_from_int_instr_done_i) && !$past(active_level_o[1]))
		else $error("low level freed out of order");
	AST_GIE: assert property ($rose(call_busy_o) |-> $past(gie) || $past(gie, 2))
		else $error("call taken with global enable off");
	AST_IP_ONES: assert property (reg_rd_i && reg_addr_i == `VIH_A_IP |=> reg_rdata_o[7:6] == 2'b11)
		else $error("priority register top bits not ones");
endmodule : vih_handler_chk

bind vih_handler vih_handler_chk #(.NUM_SRC(NUM_SRC)) vih_handler_chk_i (.core_clk_i, .rst_n_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .return_from_int_instr_done_i, .call_req_o, .call_addr_o, .call_src_o,
	.call_busy_o, .active_level_o);
